// File: common/ivg_map.svh
// Constant map of the interrupt vector generation block
`ifndef IVG_MAP_SVH
`define IVG_MAP_SVH
// ==========================================
// Offset register indices per interrupt type
`define IVG_IDX_CRIT 6'h00
`define IVG_IDX_MCHK 6'h01
`define IVG_IDX_DSTOR 6'h02
`define IVG_IDX_ISTOR 6'h03
`define IVG_IDX_EXT 6'h04
`define IVG_IDX_ALIGN 6'h05
`define IVG_IDX_PROG 6'h06
`define IVG_IDX_FPU 6'h07
`define IVG_IDX_SYSC 6'h08
`define IVG_IDX_AUX 6'h09
`define IVG_IDX_DEC 6'h0A
`define IVG_IDX_FIT 6'h0B
`define IVG_IDX_WDOG 6'h0C
`define IVG_IDX_DTLB 6'h0D
`define IVG_IDX_ITLB 6'h0E
`define IVG_IDX_DEBUG 6'h0F
`define IVG_IDX_VEC_UNAV 6'h20
`define IVG_IDX_VEC_DATA 6'h21
`define IVG_IDX_VEC_RND 6'h22
`define IVG_IDX_LOW_TOP 6'h0F
`define IVG_NUM_OFFSETS 35
// ==========================================
// Special-register selects outside the offset range
`define IVG_SEL_PREFIX 6'h3F
`define IVG_SEL_FAULT 6'h3E
// ==========================================
// Field positions and fixed values
`define IVG_PFX_MSB 31
`define IVG_PFX_LSB 16
`define IVG_OFF_MSB 15
`define IVG_OFF_LSB 4
`define IVG_VEC_LOW 4'h0
`define IVG_RST_LOW 12'hFFC
`define IVG_BOOT_WAIT 2'h2
`endif

// File: common/ivg_pkg.sv
// Types of the interrupt vector generation block
package ivg_pkg;
  // ==========================================
  // Save/restore resource class
  typedef enum logic [1:0] {
    ivg_cls_nc,
    ivg_cls_crit,
    ivg_cls_dbg
  } ivg_cls_t;
  // ==========================================
  // Return instruction kind
  typedef enum logic [1:0] {
    ivg_ret_nc,
    ivg_ret_crit,
    ivg_ret_dbg
  } ivg_ret_t;
endpackage

// File: design/ivg_vector_unit.sv
// Interrupt vector generation, save/restore and fault address capture
//
// Notes on behaviour
// - A vector address is prefix bits 32-47, the offset register's bits 48-59 and four zero bits.
// - Taking an interrupt redirects fetch to the vector address built for it.
// - Prefix and offset registers are not reset and software must load them before relying on interrupts.
// - Reset is no interrupt and fetch starts at the 20-bit reset base followed by 0xFFC.
// - Offset indices 0 to 9 serve critical, machine check, data and instruction storage, external, alignment, program, FPU, syscall and aux unit.
// - Offset indices 10 to 15 serve decrementer, fixed timer, watchdog, data and instruction miss and debug, 32 to 34 the vector unit.
// - Autovectored external and critical requests take their offset from their offset register.
// - Vectored requests use the offset supplied by the external controller.
// - Alignment, data miss and data storage from a memory access record the referenced address.
// - Non-critical interrupts use the non-critical save pair and return, async ones blocked by the external enable.
// - Critical interrupts may nest over non-critical ones, use the critical pair and are blocked by the critical enable.
// - Debug uses the critical pair and its return is illegal when the select bit is 0, the debug pair when 1.
`timescale 1ns/1ps
`include "ivg_map.svh"
module ivg_vector_unit (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // Reset base strap pins
  input wire logic [19:0] rst_base,
  // Special-register access
  input wire logic spr_we,
  input wire logic spr_re,
  input wire logic [5:0] spr_sel,
  input wire logic [31:0] spr_wdata,
  output logic [31:0] spr_rdata,
  // Machine state bits
  input wire logic external_enable_bit,
  input wire logic critical_enable_bit,
  input wire logic debug_unit_select,
  // Current context from the pipeline
  input wire logic [31:0] cur_pc,
  input wire logic [31:0] cur_state,
  // Pipeline exceptions
  input wire logic exc_valid,
  input wire logic [5:0] exc_type,
  input wire logic exc_is_mem,
  input wire logic [31:0] exc_addr,
  output logic exc_taken,
  // External controller requests
  input wire logic ext_req,
  input wire logic ext_vectored,
  input wire logic [11:0] ext_offset,
  output logic ext_ack,
  input wire logic crit_req,
  input wire logic crit_vectored,
  input wire logic [11:0] crit_offset,
  output logic crit_ack,
  // Return instructions
  input wire logic ret_valid,
  input wire ivg_pkg::ivg_ret_t ret_kind,
  output logic restore_valid,
  output logic [31:0] restore_state,
  output logic illegal_ret,
  // Fetch redirect
  output logic fetch_valid,
  output logic [31:0] fetch_addr,
  // Saved context and fault address
  output logic [31:0] noncrit_save_addr,
  output logic [31:0] noncrit_save_state,
  output logic [31:0] crit_save_addr,
  output logic [31:0] crit_save_state,
  output logic [31:0] dbg_save_addr,
  output logic [31:0] dbg_save_state,
  output logic [31:0] data_fault_address
);
  // ==========================================
  // Decode helpers
  function automatic logic idx_ok(input logic [5:0] idx);
    idx_ok = (idx <= `IVG_IDX_LOW_TOP) ||
             (idx == `IVG_IDX_VEC_UNAV) ||
             (idx == `IVG_IDX_VEC_DATA) ||
             (idx == `IVG_IDX_VEC_RND);
  endfunction

  function automatic logic [5:0] idx_slot(input logic [5:0] idx);
    if (idx <= `IVG_IDX_LOW_TOP) begin
      idx_slot = idx;
    end else begin
      idx_slot = idx - `IVG_IDX_VEC_UNAV + `IVG_IDX_LOW_TOP + 6'h01;
    end
  endfunction

  function automatic logic [31:0] vec_addr(input logic [15:0] pfx, input logic [11:0] off);
    vec_addr = {pfx, off, `IVG_VEC_LOW};
  endfunction

  // ==========================================
  // Software-loaded vector registers, no reset
  logic [15:0] vector_prefix;
  logic [11:0] vector_offset_n [`IVG_NUM_OFFSETS];

  always_ff @(posedge mclk) begin
    if (ce && spr_we) begin
      if (spr_sel == `IVG_SEL_PREFIX) begin
        vector_prefix <= spr_wdata[`IVG_PFX_MSB:`IVG_PFX_LSB];
      end else if (idx_ok(spr_sel)) begin
        vector_offset_n[idx_slot(spr_sel)] <= spr_wdata[`IVG_OFF_MSB:`IVG_OFF_LSB];
      end
    end
  end

  // ==========================================
  // Reset base strap synchroniser
  logic [19:0] base_meta;
  logic [19:0] base_sync;
  logic [19:0] next_base_meta;
  logic [19:0] next_base_sync;

  always_comb begin
    next_base_meta = rst_base;
    next_base_sync = base_meta;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      base_meta <= 20'h00000;
      base_sync <= 20'h00000;
    end else if (ce) begin
      base_meta <= next_base_meta;
      base_sync <= next_base_sync;
    end
  end

  // ==========================================
  // Boot sequencing and interrupt selection
  typedef enum logic [1:0] {ivg_st_boot, ivg_st_run} ivg_state_t;

  ivg_state_t state;
  ivg_state_t next_state;
  logic [1:0] boot_cnt;
  logic [1:0] next_boot_cnt;

  logic take;
  logic take_pipe;
  logic take_ext;
  logic take_crit;
  logic [5:0] take_idx;
  logic [11:0] take_off;
  ivg_pkg::ivg_cls_t take_cls;
  logic pipe_async_nc;
  logic pipe_async_cr;
  logic pipe_allowed;

  always_comb begin
    next_state = state;
    next_boot_cnt = boot_cnt;
    if (state == ivg_st_boot) begin
      next_boot_cnt = boot_cnt + 2'h1;
      if (boot_cnt == `IVG_BOOT_WAIT) begin
        next_state = ivg_st_run;
      end
    end
  end

  always_comb begin
    pipe_async_nc = (exc_type == `IVG_IDX_DEC) || (exc_type == `IVG_IDX_FIT);
    pipe_async_cr = (exc_type == `IVG_IDX_WDOG) || (exc_type == `IVG_IDX_MCHK);
    pipe_allowed = idx_ok(exc_type) &&
                   !(pipe_async_nc && !external_enable_bit) &&
                   !(pipe_async_cr && !critical_enable_bit);
    take_pipe = 1'b0;
    take_crit = 1'b0;
    take_ext = 1'b0;
    take_idx = exc_type;
    take_off = 12'h000;
    take_cls = ivg_pkg::ivg_cls_nc;
    if (state == ivg_st_run) begin
      if (exc_valid && pipe_allowed) begin
        take_pipe = 1'b1;
        take_off = vector_offset_n[idx_slot(exc_type)];
      end else if (crit_req && critical_enable_bit && !crit_ack) begin
        take_crit = 1'b1;
        take_idx = `IVG_IDX_CRIT;
        // Vectored offset sampled at acceptance
        take_off = crit_vectored ? crit_offset : vector_offset_n[`IVG_IDX_CRIT];
      end else if (ext_req && external_enable_bit && !ext_ack) begin
        take_ext = 1'b1;
        take_idx = `IVG_IDX_EXT;
        take_off = ext_vectored ? ext_offset : vector_offset_n[`IVG_IDX_EXT];
      end
    end
    take = take_pipe || take_crit || take_ext;
    if (take_idx == `IVG_IDX_DEBUG) begin
      take_cls = debug_unit_select ? ivg_pkg::ivg_cls_dbg : ivg_pkg::ivg_cls_crit;
    end else if ((take_idx == `IVG_IDX_CRIT) || (take_idx == `IVG_IDX_MCHK) ||
                 (take_idx == `IVG_IDX_WDOG)) begin
      take_cls = ivg_pkg::ivg_cls_crit;
    end
  end

  // ==========================================
  // Fetch, save/restore and fault address
  logic next_fetch_valid;
  logic [31:0] next_fetch_addr;
  logic next_exc_taken;
  logic next_ext_ack;
  logic next_crit_ack;
  logic next_restore_valid;
  logic [31:0] next_restore_state;
  logic next_illegal_ret;
  logic [31:0] next_nc_addr;
  logic [31:0] next_nc_state;
  logic [31:0] next_cr_addr;
  logic [31:0] next_cr_state;
  logic [31:0] next_db_addr;
  logic [31:0] next_db_state;
  logic [31:0] next_fault;
  logic [31:0] next_spr_rdata;

  always_comb begin
    next_fetch_valid = 1'b0;
    next_fetch_addr = fetch_addr;
    next_exc_taken = take_pipe;
    next_ext_ack = take_ext;
    next_crit_ack = take_crit;
    next_restore_valid = 1'b0;
    next_restore_state = restore_state;
    next_illegal_ret = 1'b0;
    next_nc_addr = noncrit_save_addr;
    next_nc_state = noncrit_save_state;
    next_cr_addr = crit_save_addr;
    next_cr_state = crit_save_state;
    next_db_addr = dbg_save_addr;
    next_db_state = dbg_save_state;
    next_fault = data_fault_address;
    next_spr_rdata = spr_rdata;
    if ((state == ivg_st_boot) && (boot_cnt == `IVG_BOOT_WAIT)) begin
      next_fetch_valid = 1'b1;
      next_fetch_addr = {base_sync, `IVG_RST_LOW};
    end else if (take) begin
      next_fetch_valid = 1'b1;
      next_fetch_addr = vec_addr(vector_prefix, take_off);
      unique case (take_cls)
        ivg_pkg::ivg_cls_nc: begin
          next_nc_addr = cur_pc;
          next_nc_state = cur_state;
        end
        ivg_pkg::ivg_cls_crit: begin
          next_cr_addr = cur_pc;
          next_cr_state = cur_state;
        end
        default: begin
          next_db_addr = cur_pc;
          next_db_state = cur_state;
        end
      endcase
      if (take_pipe && exc_is_mem &&
          ((exc_type == `IVG_IDX_ALIGN) || (exc_type == `IVG_IDX_DTLB) ||
           (exc_type == `IVG_IDX_DSTOR))) begin
        next_fault = exc_addr;
      end
    end else if (ret_valid && (state == ivg_st_run)) begin
      unique case (ret_kind)
        ivg_pkg::ivg_ret_nc: begin
          next_fetch_valid = 1'b1;
          next_fetch_addr = noncrit_save_addr;
          next_restore_valid = 1'b1;
          next_restore_state = noncrit_save_state;
        end
        ivg_pkg::ivg_ret_crit: begin
          next_fetch_valid = 1'b1;
          next_fetch_addr = crit_save_addr;
          next_restore_valid = 1'b1;
          next_restore_state = crit_save_state;
        end
        default: begin
          if (debug_unit_select) begin
            next_fetch_valid = 1'b1;
            next_fetch_addr = dbg_save_addr;
            next_restore_valid = 1'b1;
            next_restore_state = dbg_save_state;
          end else begin
            next_illegal_ret = 1'b1;
          end
        end
      endcase
    end
    if (spr_re) begin
      if (spr_sel == `IVG_SEL_PREFIX) begin
        next_spr_rdata = {vector_prefix, 16'h0000};
      end else if (spr_sel == `IVG_SEL_FAULT) begin
        next_spr_rdata = data_fault_address;
      end else if (idx_ok(spr_sel)) begin
        next_spr_rdata = {16'h0000, vector_offset_n[idx_slot(spr_sel)], 4'h0};
      end else begin
        next_spr_rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= ivg_st_boot;
      boot_cnt <= 2'h0;
      fetch_valid <= 1'b0;
      fetch_addr <= 32'h00000000;
      exc_taken <= 1'b0;
      ext_ack <= 1'b0;
      crit_ack <= 1'b0;
      restore_valid <= 1'b0;
      restore_state <= 32'h00000000;
      illegal_ret <= 1'b0;
      noncrit_save_addr <= 32'h00000000;
      noncrit_save_state <= 32'h00000000;
      crit_save_addr <= 32'h00000000;
      crit_save_state <= 32'h00000000;
      dbg_save_addr <= 32'h00000000;
      dbg_save_state <= 32'h00000000;
      data_fault_address <= 32'h00000000;
      spr_rdata <= 32'h00000000;
    end else if (ce) begin
      state <= next_state;
      boot_cnt <= next_boot_cnt;
      fetch_valid <= next_fetch_valid;
      fetch_addr <= next_fetch_addr;
      exc_taken <= next_exc_taken;
      ext_ack <= next_ext_ack;
      crit_ack <= next_crit_ack;
      restore_valid <= next_restore_valid;
      restore_state <= next_restore_state;
      illegal_ret <= next_illegal_ret;
      noncrit_save_addr <= next_nc_addr;
      noncrit_save_state <= next_nc_state;
      crit_save_addr <= next_cr_addr;
      crit_save_state <= next_cr_state;
      dbg_save_addr <= next_db_addr;
      dbg_save_state <= next_db_state;
      data_fault_address <= next_fault;
      spr_rdata <= next_spr_rdata;
    end
  end
endmodule

// File: tb/ivg_ctl_model.sv
// Behavioural external interrupt controller
`timescale 1ns/1ps
module ivg_ctl_model (
  // Clock and bench command
  input wire logic mclk,
  input wire logic start,
  input wire logic chan,
  input wire logic s_vec,
  input wire logic [11:0] s_off,
  // Requests, 0 external, 1 critical
  input wire logic [1:0] ack,
  output logic [1:0] req,
  output logic [1:0] vec,
  output logic [1:0][11:0] off
);
  initial begin
    req = 2'h0;
    vec = 2'h0;
    off = 24'h5A5A5A;
  end
  // Hold until ack is sampled, then drop and scramble offsets
  always @(posedge mclk) begin
    if (start && req == 2'h0) begin
      #1;
      req[chan] = 1'h1;
      vec[chan] = s_vec;
      off[chan] = s_off;
    end else if ((req & ack) != 2'h0) begin
      #1;
      req = 2'h0;
      off = ~off;
    end
  end
endmodule

// File: tb/ivg_monitor.sv
// Assertion checker bound to the vector unit
`timescale 1ns/1ps
module ivg_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register writes, straps, state bits
  input wire logic ce,
  input wire logic [19:0] rst_base,
  input wire logic spr_we,
  input wire logic [5:0] spr_sel,
  input wire logic [31:0] spr_wdata,
  input wire logic external_enable_bit,
  input wire logic critical_enable_bit,
  input wire logic debug_unit_select,
  // Takes and returns
  input wire logic [5:0] exc_type,
  input wire logic exc_is_mem,
  input wire logic [31:0] exc_addr,
  input wire logic exc_taken,
  input wire logic ext_vectored,
  input wire logic [11:0] ext_offset,
  input wire logic ext_ack,
  input wire logic crit_ack,
  input wire ivg_pkg::ivg_ret_t ret_kind,
  input wire logic illegal_ret,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire logic [31:0] data_fault_address
);
  logic [15:0] pfx;
  logic [11:0] offs [64];
  // Shadow of the vector registers
  always_ff @(posedge mclk) begin
    if (ce && spr_we) begin
      if (spr_sel == 6'h3F) begin
        pfx <= spr_wdata[31:16];
      end
      offs[spr_sel] <= spr_wdata[15:4];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  boot_vector_a: assert property ($rose(nrst) |-> ##[1:4] (fetch_valid && fetch_addr == {rst_base, 12'hFFC}))
    else $error("boot fetch address wrong");
  exc_vector_a: assert property (exc_taken |-> fetch_valid && fetch_addr == {pfx, offs[$past(exc_type)], 4'h0})
    else $error("exception vector wrong");
  ext_vector_a: assert property (ext_ack && $past(ext_vectored) |-> fetch_addr == {pfx, $past(ext_offset), 4'h0})
    else $error("vectored fetch address wrong");
  ext_auto_a: assert property (ext_ack && !$past(ext_vectored) |-> fetch_addr == {pfx, offs[4], 4'h0})
    else $error("autovectored fetch address wrong");
  ext_mask_a: assert property (ext_ack |-> $past(external_enable_bit))
    else $error("external take while masked");
  crit_mask_a: assert property (crit_ack |-> $past(critical_enable_bit))
    else $error("critical take while masked");
  fault_capture_a: assert property (exc_taken && $past(exc_is_mem) && ($past(exc_type) inside {6'h02, 6'h05, 6'h0D})
    |-> data_fault_address == $past(exc_addr)) else $error("fault address not captured");
  bad_return_a: assert property (illegal_ret |-> !fetch_valid && !$past(debug_unit_select)
    && $past(ret_kind) == ivg_pkg::ivg_ret_dbg) else $error("illegal return flagged wrongly");
  cover property (ext_ack && $past(ext_vectored));
  cover property (crit_ack);
  cover property (illegal_ret);
endmodule
bind ivg_vector_unit ivg_chk ivg_chk_i (.mclk, .nrst, .ce, .rst_base, .spr_we, .spr_sel, .spr_wdata,
  .external_enable_bit, .critical_enable_bit, .debug_unit_select, .exc_type, .exc_is_mem, .exc_addr,
  .exc_taken, .ext_vectored, .ext_offset, .ext_ack, .crit_ack, .ret_kind, .illegal_ret, .fetch_valid,
  .fetch_addr, .data_fault_address);

// File: tb/ivg_vector_unit_tb_top.sv
// Self-checking bench of the vector unit
`timescale 1ns/1ps
module ivg_vector_unit_tb_top;
  localparam logic [15:0] PF = 16'hA5C3;
  localparam logic [19:0] RB = 20'h3C5A9;
  logic mclk = 1'h0, nrst = 1'h0, ce = 1'h1, spr_we = 1'h0, spr_re = 1'h0, exc_valid = 1'h0, exc_is_mem = 1'h1;
  logic external_enable_bit = 1'h1, critical_enable_bit = 1'h1, debug_unit_select = 1'h1, ret_valid = 1'h0;
  logic go = 1'h0, go_c = 1'h0, go_v = 1'h0, exc_taken, restore_valid, illegal_ret, fetch_valid;
  logic [19:0] rst_base = RB;
  logic [5:0] spr_sel = 6'h00, exc_type = 6'h00;
  logic [11:0] go_o = 12'h000;
  logic [31:0] spr_wdata = 32'h0, cur_pc = 32'h0, cur_state = 32'h0, exc_addr = 32'h0, spr_rdata, restore_state;
  logic [31:0] fetch_addr, noncrit_save_addr, noncrit_save_state, crit_save_addr, crit_save_state;
  logic [31:0] dbg_save_addr, dbg_save_state, data_fault_address;
  logic [1:0] req, vec, ack;
  logic [1:0][11:0] off;
  ivg_pkg::ivg_ret_t ret_kind = ivg_pkg::ivg_ret_nc;
  int n_errors = 0, num_checks = 0;
  always #10 mclk = ~mclk;
  ivg_ctl_model ivg_ctl_model_i (.mclk, .start(go), .chan(go_c), .s_vec(go_v), .s_off(go_o), .ack, .req, .vec, .off);
  ivg_vector_unit ivg_vector_unit_i (.mclk, .nrst, .ce, .rst_base, .spr_we, .spr_re, .spr_sel, .spr_wdata,
    .spr_rdata, .external_enable_bit, .critical_enable_bit, .debug_unit_select, .cur_pc, .cur_state,
    .exc_valid, .exc_type, .exc_is_mem, .exc_addr, .exc_taken,
    .ext_req(req[0]), .ext_vectored(vec[0]), .ext_offset(off[0]), .ext_ack(ack[0]),
    .crit_req(req[1]), .crit_vectored(vec[1]), .crit_offset(off[1]), .crit_ack(ack[1]),
    .ret_valid, .ret_kind, .restore_valid, .restore_state, .illegal_ret, .fetch_valid, .fetch_addr,
    .noncrit_save_addr, .noncrit_save_state, .crit_save_addr, .crit_save_state,
    .dbg_save_addr, .dbg_save_state, .data_fault_address);
  // Table position to offset index and loaded offset
  function automatic logic [5:0] ix(input int i);
    return (i < 16) ? 6'(i) : 6'(i + 16);
  endfunction
  function automatic logic [11:0] ov(input int i);
    return {6'h2B, ix(i)};
  endfunction
  task automatic cyc();
    @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_rd(input logic [5:0] sel, input logic [31:0] d, input logic [31:0] e);
    spr_sel = sel;
    spr_wdata = d;
    spr_we = 1'h1;
    cyc();
    spr_we = 1'h0;
    spr_re = 1'h1;
    cyc();
    spr_re = 1'h0;
    chk(spr_rdata, e);
    cyc();
  endtask
  // Source 0 external, 1 critical, 2 pipeline exception
  task automatic take(input logic [1:0] c, input logic v, input logic [11:0] o, input logic [31:0] pc);
    int k;
    cur_pc = pc;
    cur_state = ~pc;
    exc_addr = ~pc;
    exc_type = o[5:0];
    exc_valid = (c == 2'h2);
    go_c = c[0];
    go_v = v;
    go_o = o;
    go = (c != 2'h2);
    for (k = 0; k < 12 && {exc_taken, ack} === 3'h0; k++)
      cyc();
    go = 1'h0;
    exc_valid = 1'h0;
    cyc();
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    int i;
    logic [11:0] o;
    logic [31:0] fa, sv, e;
    fa = 32'h0;
    repeat (16) @(posedge mclk);
    #1;
    nrst = 1'h1;
    for (i = 0; i < 8 && fetch_valid !== 1'h1; i++)
      cyc();
    chk(fetch_addr, {RB, 12'hFFC});
    $display("boot test done");
    wr_rd(6'h3F, {PF, 16'h1234}, {PF, 16'h0000});
    for (i = 0; i < 19; i++)
      wr_rd(ix(i), {16'hFFFF, ov(i), 4'hF}, {16'h0000, ov(i), 4'h0});
    wr_rd(6'h10, 32'hFFFFFFFF, 32'h0);
    wr_rd(6'h3E, 32'hFFFFFFFF, 32'h0);
    // Frozen by the enable: write lost, read data held
    ce = 1'h0;
    wr_rd(6'h3F, 32'h0, 32'h0);
    ce = 1'h1;
    $display("register test done");
    for (i = 0; i < 19; i++) begin
      take(2'h2, 1'h0, {6'h00, ix(i)}, {26'h1555555, ix(i)});
      if (ix(i) inside {6'h02, 6'h05, 6'h0D})
        fa = ~cur_pc;
      sv = (ix(i) == 6'h0F) ? dbg_save_addr : noncrit_save_addr;
      chk(fetch_addr, {PF, ov(i), 4'h0});
      chk(data_fault_address, fa);
      chk(ix(i) inside {6'h00, 6'h01, 6'h0C} ? crit_save_addr : sv, cur_pc);
      sv = (ix(i) == 6'h0F) ? dbg_save_state : noncrit_save_state;
      chk(ix(i) inside {6'h00, 6'h01, 6'h0C} ? crit_save_state : sv, ~cur_pc);
    end
    external_enable_bit = 1'h0;
    exc_type = 6'h0A;
    exc_valid = 1'h1;
    repeat (6) cyc();
    chk(noncrit_save_addr, {26'h1555555, 6'h22});
    external_enable_bit = 1'h1;
    take(2'h2, 1'h0, 12'h00A, 32'h0);
    chk(noncrit_save_addr, 32'h0);
    $display("exception test done");
    for (i = 0; i < 4; i++) begin
      o = i[0] ? 12'h3A0 + 12'(i) : 12'h000;
      take(2'(i / 2), i[0], o, {20'hC0DE0, o});
      chk(fetch_addr, {PF, i[0] ? o : ov(i < 2 ? 4 : 0), 4'h0});
      chk(i < 2 ? noncrit_save_addr : crit_save_addr, cur_pc);
    end
    $display("request test done");
    for (i = 0; i < 3; i++) begin
      debug_unit_select = (i != 2);
      ret_kind = ivg_pkg::ivg_ret_t'(i);
      ret_valid = 1'h1;
      cyc();
      ret_valid = 1'h0;
      e = {20'hC0DE0, i > 0 ? 12'h3A3 : 12'h3A1};
      chk(fetch_addr, e);
      chk(restore_state, ~e);
      chk({31'h0, illegal_ret}, {31'h0, i == 2});
      chk({31'h0, restore_valid}, {31'h0, i != 2});
      cyc();
    end
    $display("return test done");
    report_and_stop();
  end
  // About thirty times the expected run
  initial begin
    #100000;
    n_errors++;
    report_and_stop();
  end
endmodule
